/* conv_post.sv */
// Converter control, timing, correction, averaging and compare logic
`default_nettype none
module conv_post #(
  parameter int MUX_W = 5
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event trigger pin
  input wire logic start_event,
  // Analog core side
  input wire logic [11:0] raw_data,
  output logic converter_clock,
  output logic sample_strobe,
  output logic [MUX_W-1:0] positive_input_select,
  // Status outputs
  output logic conv_done,
  output logic compare_event
);
  initial begin
    if (MUX_W < 2 || MUX_W > 8) begin
      $error("MUX_W out of range");
    end
  end

  typedef struct packed {
    conv_pkg::ctrl_t ctrl;
    conv_pkg::timing_t tim;
    logic [MUX_W-1:0] mux_first;
    logic [MUX_W-1:0] mux_count;
    logic [MUX_W-1:0] mux_idx;
    logic [11:0] offset_trim_value;
    logic [11:0] gain_trim_factor;
    logic [11:0] cmp_thr;
    logic [3:0] sample_count_exponent;
    logic [2:0] extra_shift_count;
    logic [15:0] result;
    logic done_flag;
    logic cmp_flag;
    logic start_pend;
    conv_pkg::state_t state;
    logic [7:0] presc_cnt;
    logic cclk;
    logic [5:0] half_cnt;
    logic [3:0] corr_cnt;
    logic first_done;
    logic [21:0] acc;
    logic [10:0] acc_cnt;
    logic [1:0] ev_sync;
    logic ev_prev;
    logic done_p;
    logic cmp_p;
    logic samp_p;
    logic [11:0] cur;
  } st_t;

  st_t s_r, s_nxt;

  // Correct one raw sample: offset then gain, scaled and limited
  function automatic logic [11:0] correct(input logic [11:0] raw,
      input logic [11:0] off, input logic [11:0] gain);
    logic signed [13:0] diff;
    logic signed [26:0] prod;
    logic signed [26:0] scaled;
    diff = $signed({2'b00, raw}) - $signed({2'b00, off});
    prod = diff * $signed({15'h0000, gain});
    scaled = prod >>> conv_pkg::GAIN_SHIFT;
    if (scaled < 0) begin
      correct = 12'h000;
    end else if (scaled > 27'sh0000FFF) begin
      correct = 12'hFFF;
    end else begin
      correct = scaled[11:0];
    end
  endfunction

  // Conversion length in half converter clocks
  function automatic logic [5:0] conv_halves(input conv_pkg::fmt_t f,
      input logic [3:0] sv, input logic [1:0] pen);
    logic [5:0] res;
    res = (f == conv_pkg::FMT_R8) ? 6'h08 : 6'h0C;
    conv_halves = res + {2'b00, sv} + {3'b000, pen, 1'b0};
  endfunction

  // Automatic right shift for 2^exp accumulated samples
  function automatic logic [2:0] auto_shift(input logic [3:0] e);
    auto_shift = (e > 4'h4) ? 3'(e - 4'h4) : 3'h0;
  endfunction

  logic [11:0] corr_val;
  logic [21:0] acc_sum;
  logic [21:0] avg_shifted;
  logic [15:0] avg_val;
  logic [15:0] fmt_val;
  logic cmp_hit;
  logic cclk_rise;
  logic apb_wr;

  // Offset always applies; without gain a negative difference floors
  // at zero like the gain path, so a large trim never wraps to full scale
  assign corr_val = s_r.ctrl.corr_en ?
      correct(s_r.cur, s_r.offset_trim_value, s_r.gain_trim_factor) :
      ((s_r.cur < s_r.offset_trim_value) ? 12'h000 :
      (s_r.cur - s_r.offset_trim_value));
  assign acc_sum = s_r.acc + {10'h000, corr_val};
  // Both the auto shift and the software shift apply
  assign avg_shifted = (acc_sum >> auto_shift(s_r.sample_count_exponent))
      >> s_r.extra_shift_count;
  // Saturate to 16 bits rather than wrap
  assign avg_val = (|avg_shifted[21:16]) ? 16'hFFFF : avg_shifted[15:0];
  always_comb begin
    case (s_r.ctrl.fmt)
      conv_pkg::FMT_R12: fmt_val = {4'h0, corr_val};
      conv_pkg::FMT_OVS: fmt_val = avg_val;
      conv_pkg::FMT_R8: fmt_val = {8'h00, corr_val[11:4]};
      conv_pkg::FMT_L12: fmt_val = {corr_val, 4'h0};
      default: fmt_val = {4'h0, corr_val};
    endcase
  end
  // Threshold compares on the 12-bit corrected value
  assign cmp_hit = !s_r.ctrl.cmp_en ? 1'b1 :
      (s_r.ctrl.cmp_below ? (corr_val < s_r.cmp_thr) :
      (corr_val > s_r.cmp_thr));
  assign cclk_rise = (s_r.presc_cnt == s_r.tim.presc) && !s_r.cclk;
  assign apb_wr = psel && penable && pwrite;

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.done_p = 1'b0;
    s_nxt.cmp_p = 1'b0;
    s_nxt.samp_p = 1'b0;
    s_nxt.ev_sync = {s_r.ev_sync[0], start_event};
    s_nxt.ev_prev = s_r.ev_sync[1];
    // Prescaler: half period is presc+1 peripheral clocks
    if (s_r.presc_cnt == s_r.tim.presc) begin
      s_nxt.presc_cnt = 8'h00;
      s_nxt.cclk = ~s_r.cclk;
    end else begin
      s_nxt.presc_cnt = s_r.presc_cnt + 8'h01;
    end
    // Event rising edge is a start request
    if (s_r.ctrl.evt_en && s_r.ev_sync[1] && !s_r.ev_prev) begin
      s_nxt.start_pend = 1'b1;
    end
    case (s_r.state)
      conv_pkg::ST_IDLE: begin
        s_nxt.first_done = 1'b0;
        // Pending start latched earlier, taken on a converter edge
        if (s_r.start_pend && cclk_rise) begin
          s_nxt.start_pend = 1'b0;
          s_nxt.state = conv_pkg::ST_CONV;
          s_nxt.half_cnt = conv_halves(s_r.ctrl.fmt, s_r.tim.sampling_time_value,
              s_r.tim.gain_pen);
          s_nxt.mux_idx = '0;
          s_nxt.acc = '0;
          s_nxt.acc_cnt = '0;
          s_nxt.samp_p = 1'b1;
        end
      end
      conv_pkg::ST_CONV: begin
        if (s_r.presc_cnt == s_r.tim.presc) begin
          if (s_r.half_cnt == 6'h01) begin
            s_nxt.cur = raw_data;
            if (s_r.ctrl.corr_en && !s_r.first_done) begin
              s_nxt.state = conv_pkg::ST_CORR;
              s_nxt.corr_cnt = 4'(conv_pkg::CORR_LATENCY - 1);
            end else begin
              s_nxt.state = conv_pkg::ST_ACC;
            end
          end else begin
            s_nxt.half_cnt = s_r.half_cnt - 6'h01;
          end
        end
      end
      // Correction wait; the prescaler keeps running meanwhile, so
      // later free-run conversions stay on the converter clock grid
      conv_pkg::ST_CORR: begin
        if (s_r.corr_cnt == 4'h0) begin
          s_nxt.state = conv_pkg::ST_ACC;
        end else begin
          s_nxt.corr_cnt = s_r.corr_cnt - 4'h1;
        end
      end
      // One cycle to store; the next sample starts here in scan or free run
      conv_pkg::ST_ACC: begin
        s_nxt.first_done = 1'b1;
        s_nxt.state = conv_pkg::ST_CONV;
        s_nxt.half_cnt = conv_halves(s_r.ctrl.fmt, s_r.tim.sampling_time_value,
            s_r.tim.gain_pen);
        s_nxt.samp_p = 1'b1;
        if (s_r.ctrl.fmt == conv_pkg::FMT_OVS &&
            s_r.acc_cnt != (11'h001 << s_r.sample_count_exponent) - 11'h001)
            begin
          s_nxt.acc = acc_sum;
          s_nxt.acc_cnt = s_r.acc_cnt + 11'h001;
        end else begin
          s_nxt.acc = '0;
          s_nxt.acc_cnt = '0;
          s_nxt.result = fmt_val;
          s_nxt.done_p = 1'b1;
          s_nxt.done_flag = 1'b1;
          if (cmp_hit) begin
            s_nxt.cmp_p = 1'b1;
            s_nxt.cmp_flag = 1'b1;
          end
          if (s_r.mux_idx + 1'b1 < s_r.mux_count) begin
            s_nxt.mux_idx = s_r.mux_idx + 1'b1;
          end else begin
            s_nxt.mux_idx = '0;
            if (!s_r.ctrl.freerun) begin
              s_nxt.state = conv_pkg::ST_IDLE;
              s_nxt.samp_p = 1'b0;
            end
          end
        end
      end
      default: s_nxt.state = conv_pkg::ST_IDLE;
    endcase
    // Register writes; hardware set beats software clear
    if (apb_wr) begin
      case (paddr)
        conv_pkg::CTRL_ADDR: begin
          if (pwdata[conv_pkg::START_BIT]) begin
            s_nxt.start_pend = 1'b1;
          end
          s_nxt.ctrl.freerun = pwdata[conv_pkg::FREERUN_BIT];
          s_nxt.ctrl.corr_en = pwdata[conv_pkg::CORR_EN_BIT];
          s_nxt.ctrl.fmt = conv_pkg::fmt_t'(pwdata[conv_pkg::FMT_LSB +: 2]);
          s_nxt.ctrl.cmp_en = pwdata[conv_pkg::CMP_EN_BIT];
          s_nxt.ctrl.cmp_below = pwdata[conv_pkg::CMP_BELOW_BIT];
          s_nxt.ctrl.evt_en = pwdata[conv_pkg::EVT_EN_BIT];
        end
        conv_pkg::TIMING_ADDR: s_nxt.tim = pwdata[13:0];
        conv_pkg::SCAN_ADDR: begin
          s_nxt.mux_first = pwdata[MUX_W-1:0];
          s_nxt.mux_count = pwdata[8 +: MUX_W];
        end
        conv_pkg::OFFSET_ADDR: s_nxt.offset_trim_value = pwdata[11:0];
        conv_pkg::GAIN_ADDR: begin
          // Values below half gain are clamped to the legal floor
          s_nxt.gain_trim_factor = (pwdata[11:0] < conv_pkg::GAIN_MIN) ?
              conv_pkg::GAIN_MIN : pwdata[11:0];
        end
        conv_pkg::CMP_ADDR: s_nxt.cmp_thr = pwdata[11:0];
        conv_pkg::AVG_ADDR: begin
          s_nxt.sample_count_exponent = (pwdata[3:0] > 4'(conv_pkg::MAX_EXP))
              ? 4'(conv_pkg::MAX_EXP) : pwdata[3:0];
          s_nxt.extra_shift_count = pwdata[6:4];
        end
        conv_pkg::STATUS_ADDR: begin
          if (pwdata[0] && !s_nxt.done_p) begin
            s_nxt.done_flag = 1'b0;
          end
          if (pwdata[1] && !s_nxt.cmp_p) begin
            s_nxt.cmp_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.gain_trim_factor <= conv_pkg::GAIN_RESET;
      s_r.offset_trim_value <= conv_pkg::OFFSET_RESET;
      s_r.tim.presc <= conv_pkg::PRESC_RESET;
      s_r.tim.sampling_time_value <= conv_pkg::SAMPLING_TIME_VALUE_RESET;
      s_r.state <= conv_pkg::ST_IDLE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Read mux; unmapped addresses read zero with an error
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      conv_pkg::CTRL_ADDR: prdata = {24'h000000, s_r.ctrl.evt_en,
          s_r.ctrl.cmp_below, s_r.ctrl.cmp_en, s_r.ctrl.fmt,
          s_r.ctrl.corr_en, s_r.ctrl.freerun, s_r.start_pend};
      conv_pkg::TIMING_ADDR: prdata = {18'h00000, s_r.tim};
      conv_pkg::SCAN_ADDR: prdata = 32'({s_r.mux_count, 8'(s_r.mux_first)})
          ;
      conv_pkg::OFFSET_ADDR: prdata = {20'h00000, s_r.offset_trim_value};
      conv_pkg::GAIN_ADDR: prdata = {20'h00000, s_r.gain_trim_factor};
      conv_pkg::CMP_ADDR: prdata = {20'h00000, s_r.cmp_thr};
      conv_pkg::AVG_ADDR: prdata = {25'h0000000, s_r.extra_shift_count,
          s_r.sample_count_exponent};
      conv_pkg::RESULT_ADDR: prdata = {16'h0000, s_r.result};
      conv_pkg::STATUS_ADDR: prdata = {28'h0000000,
          s_r.state != conv_pkg::ST_IDLE, 1'b0, s_r.cmp_flag, s_r.done_flag};
      default: pslverr = psel && penable;
    endcase
  end

  // Zero wait states; a frozen clock enable does not stall the bus
  assign pready = 1'b1;
  assign converter_clock = s_r.cclk;
  assign sample_strobe = s_r.samp_p;
  assign positive_input_select = s_r.mux_first + s_r.mux_idx;
  assign conv_done = s_r.done_flag;
  assign compare_event = s_r.cmp_p;
endmodule
`default_nettype wire

/* conv_pkg.sv */
// Shared constants, types and register map of the converter post-processor
`default_nettype none
package conv_pkg;
  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] TIMING_ADDR = 8'h04;
  localparam logic [7:0] SCAN_ADDR = 8'h08;
  localparam logic [7:0] OFFSET_ADDR = 8'h0C;
  localparam logic [7:0] GAIN_ADDR = 8'h10;
  localparam logic [7:0] CMP_ADDR = 8'h14;
  localparam logic [7:0] AVG_ADDR = 8'h18;
  localparam logic [7:0] RESULT_ADDR = 8'h1C;
  localparam logic [7:0] STATUS_ADDR = 8'h20;
  // Control field positions
  localparam int START_BIT = 0;
  localparam int FREERUN_BIT = 1;
  localparam int CORR_EN_BIT = 2;
  localparam int FMT_LSB = 3;
  localparam int CMP_EN_BIT = 5;
  localparam int CMP_BELOW_BIT = 6;
  localparam int EVT_EN_BIT = 7;
  // Reset values and the gain floor
  localparam logic [11:0] GAIN_RESET = 12'h800;
  localparam logic [11:0] GAIN_MIN = 12'h400;
  localparam logic [11:0] OFFSET_RESET = 12'h000;
  localparam logic [7:0] PRESC_RESET = 8'h03;
  localparam logic [3:0] SAMPLING_TIME_VALUE_RESET = 4'h0;
  // Correction latency in peripheral clocks, gain scaling shift and largest averaging exponent
  localparam int CORR_LATENCY = 13;
  localparam int GAIN_SHIFT = 11;
  localparam int MAX_EXP = 10;
  // Result formats
  typedef enum logic [1:0] {
    FMT_R12 = 2'b00, FMT_OVS = 2'b01, FMT_R8 = 2'b10, FMT_L12 = 2'b11
  } fmt_t;
  // Control register fields; the start bit is kept apart as start_pend
  typedef struct packed {
    logic freerun;
    logic corr_en;
    fmt_t fmt;
    logic cmp_en;
    logic cmp_below;
    logic evt_en;
  } ctrl_t;
  // Packed from the top bit down: penalty [13:12], sampling [11:8], presc [7:0]
  typedef struct packed {
    logic [1:0] gain_pen;
    logic [3:0] sampling_time_value;
    logic [7:0] presc;
  } timing_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_CONV = 2'b01, ST_CORR = 2'b11, ST_ACC = 2'b10
  } state_t;
endpackage
`default_nettype wire

/* conv_post_props.sv */
// Port checker for the converter post-processor
`default_nettype none
module conv_post_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic converter_clock,
  input wire logic sample_strobe,
  input wire logic conv_done,
  input wire logic compare_event
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic acc, bad_addr, clr_done;
  // Unmapped means past the last word or not word aligned
  assign acc = psel && penable;
  assign bad_addr = paddr > conv_pkg::STATUS_ADDR || paddr[1:0] != 2'h0;
  assign clr_done = acc && pwrite && paddr == conv_pkg::STATUS_ADDR
    && pwdata[0];
  AST_ZERO_WAIT: assert property (acc |-> pready)
    else $error("access phase without ready");
  AST_UNMAPPED: assert property (acc && bad_addr |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && !bad_addr |-> !pslverr)
    else $error("mapped access refused");
  AST_STROBE_GAP: assert property (
    sample_strobe && clk_en |=> !sample_strobe [*7])
    else $error("conversion restarted too soon");
  AST_DONE_HOLD: assert property (
    conv_done && clk_en && !clr_done |=> conv_done)
    else $error("done flag dropped uncleared");
  AST_CMP_DONE: assert property (compare_event |-> conv_done)
    else $error("compare event without result");
  AST_CMP_PULSE: assert property (
    compare_event && clk_en |=> !compare_event)
    else $error("compare event longer than a cycle");
  AST_FREEZE: assert property (
    !clk_en |=> $stable(converter_clock) && $stable(conv_done))
    else $error("state moved while frozen");
  COV_STROBE: cover property (sample_strobe);
  COV_CMP: cover property (compare_event);
  COV_DONE: cover property ($rose(conv_done));
endmodule
bind conv_post conv_post_props u_conv_post_props (.sys_clk(sys_clk),
  .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .converter_clock(converter_clock),
  .sample_strobe(sample_strobe), .conv_done(conv_done),
  .compare_event(compare_event));
`default_nettype wire

/* conv_core_model.sv */
// Behavioural analog core: a level per selected input
`default_nettype none
module conv_core_model (
  input wire logic sys_clk,
  input wire logic sample_strobe,
  input wire logic [4:0] positive_input_select,
  input wire logic [11:0] level,
  output logic [11:0] raw_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial raw_data = 12'hA5A;
  // Held from the sample moment so each input gives its own code
  always @(posedge sys_clk) begin
    if (sample_strobe) begin
      raw_data <= level + 12'(positive_input_select);
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the converter post-processor
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, clk_en, psel, penable, pwrite, start_event;
  logic pready, pslverr, err_seen, converter_clock, sample_strobe;
  logic conv_done, compare_event, cmp_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] positive_input_select;
  logic [11:0] raw_data, level;
  int err_count, tests_run, lat, gap;
  conv_post u_conv_post (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_event(start_event), .raw_data(raw_data),
    .converter_clock(converter_clock), .sample_strobe(sample_strobe),
    .positive_input_select(positive_input_select), .conv_done(conv_done),
    .compare_event(compare_event));
  conv_core_model u_conv_core_model (.sys_clk(sys_clk),
    .sample_strobe(sample_strobe), .level(level), .raw_data(raw_data),
    .positive_input_select(positive_input_select));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: %0h, expected %0h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    print_verdict();
  endtask
  // One APB transfer; an idle edge follows so strobes never re-assert
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      if (++n > 50) give_up();
    end while (pready !== 1'h1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  // Bounded wait on the strobe (0) or the done flag (1), in cycles
  task automatic wait_sig(input logic sel);
    lat = 0;
    cmp_seen = 1'h0;
    while ((sel ? conv_done : sample_strobe) !== 1'h1) begin
      @(posedge sys_clk);
      cmp_seen = cmp_seen | (compare_event === 1'h1);
      if (++lat > 20000) give_up();
    end
  endtask
  // Start lands at any phase of the converter clock
  task automatic conv(input logic [31:0] ctrl);
    apb(1'h1, conv_pkg::STATUS_ADDR, 32'h3);
    apb(1'h1, conv_pkg::CTRL_ADDR, ctrl);
    wait_sig(1'h0);
    wait_sig(1'h1);
  endtask
  function automatic logic [31:0] want_res(input logic [11:0] x,
      input logic [1:0] f, input logic c, input logic [11:0] o,
      input logic [11:0] g);
    int y;
    y = c ? ((int'(x) - int'(o)) * int'(g)) >>> 11 : int'(x) - int'(o);
    y = y < 0 ? 0 : (y > 4095 ? 4095 : y);
    return f == 2'h2 ? 32'(y >> 4) : (f == 2'h3 ? 32'(y << 4) : 32'(y));
  endfunction
  initial begin
    {reset, clk_en} = 2'h3;
    {psel, penable, pwrite, start_event} = 4'h0;
    {paddr, pwdata, level} = 52'h0;
    {err_count, tests_run} = 0;
    void'($urandom(50));
    repeat (16) @(posedge sys_clk);
    reset <= 1'h0;
    @(posedge sys_clk);
    apb(1'h0, conv_pkg::GAIN_ADDR, 32'h0);
    check(rd, 32'(conv_pkg::GAIN_RESET));
    apb(1'h1, conv_pkg::GAIN_ADDR, 32'h100);
    apb(1'h0, conv_pkg::GAIN_ADDR, 32'h0);
    check(rd, 32'(conv_pkg::GAIN_MIN));
    apb(1'h0, 8'h40, 32'h0);
    check({rd[30:0], err_seen}, 32'h1);
    clk_en <= 1'h0;
    repeat (5) @(posedge sys_clk);
    clk_en <= 1'h1;
    // Random single conversions, first two forced into saturation
    for (int i = 0; i < 6; i++) begin
      int sv, pr, pn, hv;
      logic c;
      logic [1:0] f;
      logic [11:0] o, g;
      logic [4:0] fs;
      f = i % 3 == 0 ? 2'h0 : (i % 3 == 1 ? 2'h2 : 2'h3);
      pn = i % 3 == 2 ? 3 : i % 3;
      sv = $urandom_range(3);
      pr = $urandom_range(2);
      c = i < 2 || $urandom_range(1);
      o = 12'($urandom_range(255));
      g = i < 2 ? 12'hFFF : 12'($urandom_range(12'hFFF, 12'h400));
      fs = 5'($urandom_range(7));
      level <= i < 2 ? 12'(i ? 0 : 12'hFF0) : 12'($urandom_range(4087));
      apb(1'h1, conv_pkg::TIMING_ADDR, 32'(pr + (sv << 8) + (pn << 12)));
      apb(1'h1, conv_pkg::OFFSET_ADDR, 32'(o));
      apb(1'h1, conv_pkg::GAIN_ADDR, 32'(g));
      apb(1'h1, conv_pkg::SCAN_ADDR, 32'h100 + 32'(fs));
      conv(32'h1 + (32'(c) << 2) + (32'(f) << 3));
      hv = (f == 2'h2 ? 8 : 12) + sv + 2 * pn;
      check(32'(lat), 32'(hv * (pr + 1) + 1 + (c ? 13 : 0)));
      apb(1'h0, conv_pkg::RESULT_ADDR, 32'h0);
      check(rd, want_res(level + 12'(fs), f, c, o, g));
    end
    // Averaging and oversampling, input 0, fastest clock
    apb(1'h1, conv_pkg::TIMING_ADDR, 32'h0);
    apb(1'h1, conv_pkg::OFFSET_ADDR, 32'h0);
    apb(1'h1, conv_pkg::SCAN_ADDR, 32'h100);
    level <= 12'($urandom_range(4095));
    for (int e = 2; e < 6; e += 3) begin
      int s;
      s = e == 2 ? 1 : 0;
      apb(1'h1, conv_pkg::AVG_ADDR, 32'(e + s * 16));
      conv(32'h9);
      apb(1'h0, conv_pkg::RESULT_ADDR, 32'h0);
      check(rd, (32'(level) << e) >> (s + (e > 4 ? e - 4 : 0)));
    end
    // Threshold above, then below, on a mid-scale code
    level <= 12'h800;
    for (int k = 0; k < 3; k++) begin
      apb(1'h1, conv_pkg::CMP_ADDR, k == 2 ? 32'h801 : 32'h7FF);
      conv(32'h21 + (k > 0 ? 32'h40 : 32'h0));
      check(32'(cmp_seen), k == 1 ? 32'h0 : 32'h1);
    end
    apb(1'h0, conv_pkg::STATUS_ADDR, 32'h0);
    check(32'(rd[0]), 32'h1);
    apb(1'h1, conv_pkg::STATUS_ADDR, 32'h1);
    apb(1'h0, conv_pkg::STATUS_ADDR, 32'h0);
    check(32'(rd[0]), 32'h0);
    // Event-started scan of three inputs from input 2
    apb(1'h1, conv_pkg::SCAN_ADDR, 32'h302);
    apb(1'h1, conv_pkg::CTRL_ADDR, 32'h80);
    start_event <= 1'h1;
    @(posedge sys_clk);
    start_event <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      wait_sig(1'h0);
      check(32'(positive_input_select), 32'(k + 2));
      @(posedge sys_clk);
    end
    apb(1'h1, conv_pkg::STATUS_ADDR, 32'h3);
    wait_sig(1'h1);
    // Free run with correction: only the first result is late
    apb(1'h1, conv_pkg::SCAN_ADDR, 32'h100);
    apb(1'h1, conv_pkg::TIMING_ADDR, 32'h201);
    conv(32'h7);
    check(32'(lat), 32'(14 * 2 + 1 + 13));
    // The correction phase ended with the first result; only the second gap is checked
    for (int j = 0; j < 2; j++) begin
      gap = 0;
      do begin
        @(posedge sys_clk);
        gap++;
      end while (compare_event !== 1'h1 && gap < 200);
    end
    check(32'(gap), 32'(14 * 2));
    print_verdict();
  end
endmodule
`default_nettype wire
